// ==== flash_status_read.sv ====
// serial flash status write, protection modes and read command sequencer
//
// Contract
// [R1] dual-I/O read dummy: 4, or 8 when set
// [R2] quad-I/O read dummy: 6, or 10 when set
// [R3] status write needs write enable latch set
// [R4] status write updates protect, quad, disable bits
// [R5] host frames status write opcode then data
// [R6] execute only after exactly 8 or 16 bits
// [R7] timed write cycle; busy flag; latch clears after
// [R8] writable when disable bit clear or pin high
// [R9] disable bit and pin low reject writes
// [R10] hardware protection follows bit and low pin
// [R11] protected area refuses program and erase
// [R12] host keeps protect pin high during write
// [R13] basic read: opcode, address, data on falls
// [R14] address advances per byte, wraps to zero
// [R15] fast read has one dummy byte
// [R16] busy ignores fast, dual and quad reads
// [R17] dual-output read: 8 dummy, two-bit data
// [R18] dual-I/O read: address and data two-bit
// [R19] host holds dummy lines constant first two
// [R20] status layout: disable, quad, protect, latch, busy
// [R21] quad enable disables hardware protection
// [R22] busy flag set by any embedded operation
// [R23] top/bottom bit one-time, status write only
// [R24] second data byte loads configuration register
`default_nettype none

module flash_status_read #(
	parameter int WRITE_CYCLES = flash_pkg::STATUS_WRITE_CYCLES
) (
	// clock, reset, enable
	input  wire logic               clock_i,
	input  wire logic               rst_i,
	input  wire logic               ce_i,
	// serial pins, raw
	input  wire flash_pkg::pin_in_s pins_i,
	output logic [3:0]              io_out_o,
	output logic [3:0]              io_oe_n_o,
	// array side, same clock
	input  wire logic               ext_busy_i,
	input  wire logic [7:0]         rd_data_i,
	output logic [23:0]             rd_addr_o,
	input  wire logic               prog_req_i,
	input  wire logic [23:0]        prog_addr_i,
	output logic                    prog_ok_o,
	// register view
	output logic [7:0]              status_o,
	output logic [7:0]              config_o,
	output logic                    hardware_protect_mode_o,
	output logic                    software_protect_mode_o
);
	import flash_pkg::*;

	if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << TIMER_W))
		$error("WRITE_CYCLES out of range");

	state_s  r;
	state_s  next_r;
	pin_in_s sy;
	logic    rise;
	logic    fall;
	logic    busy;
	logic    hardware_protect_mode;
	logic    wsr_ok;
	logic [7:0] status_byte;
	logic [7:0] src_byte;
	logic [7:0] b;
	logic [2:0] alanes;
	logic [2:0] dlanes;
	logic [4:0] acnt;
	logic [23:0] an;

	pin_sync u_sync (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.pins_i      (pins_i),
		.pins_o      (sy),
		.sclk_rise_o (rise),
		.sclk_fall_o (fall)
	);

	// lines per clock: address phase when adr is set, else data phase
	function automatic logic [2:0] lanes_of(input logic [7:0] op,
		input logic adr);
		if (op == OP_QIO)
			return 3'h4;
		if (op == OP_DIO || (op == OP_DOUT && !adr))
			return 3'h2;
		return 3'h1;
	endfunction

	function automatic logic [3:0] dummy_of(input logic [7:0] op,
		input logic dc);
		case (op)
			OP_FAST: return DUMMY_FAST; // R15
			OP_DOUT: return DUMMY_DOUT; // R17
			OP_DIO:  return dc ? DUMMY_DIO_1 : DUMMY_DIO_0; // R1
			OP_QIO:  return dc ? DUMMY_QIO_1 : DUMMY_QIO_0; // R2
			default: return DUMMY_NONE;
		endcase
	endfunction

	// block-protect span from the top, or from the bottom when tb is set
	function automatic logic in_protected(input logic [3:0] bp,
		input logic tb, input logic [4:0] blk);
		logic [5:0] span;
		span = 6'h0;
		if (bp >= BP_ALL)
			span = BLK_COUNT;
		else if (bp != 4'h0)
			span = 6'h1 << (bp - 4'h1);
		return tb ? ({1'b0, blk} < span) : ({1'b0, blk} >= BLK_COUNT - span);
	endfunction

	assign busy = r.wip_own | ext_busy_i; // R22
	// quad mode turns the protect pin into a data line
	assign hardware_protect_mode = r.status_write_disable & ~sy.io[2] & ~r.qe; // R10 R21
	assign status_byte = {r.status_write_disable, r.qe, r.bp, r.write_enable_latch, r.wip_out}; // R20
	assign alanes = lanes_of(r.cmd, 1'b1);
	assign dlanes = lanes_of(r.cmd, 1'b0);
	assign acnt = r.cnt + {2'b00, alanes};
	assign wsr_ok = r.write_enable_latch & ~hardware_protect_mode & ~busy & // R3 R8 R9
		(r.wbits == WSR_SHORT || r.wbits == WSR_LONG); // R6

	always_comb
	begin
		case (r.src)
			SRC_STATUS: src_byte = status_byte;
			SRC_CONFIG: src_byte = config_o;
			default:    src_byte = rd_data_i;
		endcase
	end

	always_comb
	begin
		next_r = r;
		b = (r.obits == 4'h0) ? src_byte : r.obyte;
		an = r.addr;
		next_r.hardware_protect_mode = hardware_protect_mode;
		// own flop so the output is not an inverter after the hpm flop
		next_r.software_protect_mode = ~hardware_protect_mode;
		next_r.prog_ok = prog_req_i & // R11
			~in_protected(r.bp, r.tb, prog_addr_i[BLK_HI:BLK_LO]);
		// self-timed write; new values land only when the cycle ends
		if (r.wip_own)
		begin
			if (r.timer == '0)
			begin
				next_r.wip_own = 1'b0; // R7
				next_r.write_enable_latch = 1'b0; // R7
				{next_r.status_write_disable, next_r.qe, next_r.bp} = r.pend16 ? // R4
					r.pend[15:10] : r.pend[7:2];
				if (r.pend16)
				begin
					next_r.dc = r.pend[CR_DC]; // R24
					next_r.tb = r.tb | r.pend[CR_TB]; // R23
				end
			end
			else
				next_r.timer = r.timer - TIMER_W'(1);
		end
		if (sy.cs_n)
		begin
			// frame end: commands act on the chip-select rise
			if (r.phase == P_SKIP && r.cmd == OP_WRITE_ENABLE_CMD && !busy)
				next_r.write_enable_latch = 1'b1;
			if (r.phase == P_WDATA && wsr_ok)
			begin
				next_r.wip_own = 1'b1; // R7
				next_r.timer = TIMER_W'(WRITE_CYCLES - 1);
				next_r.pend = r.wdat;
				next_r.pend16 = (r.wbits == WSR_LONG);
			end
			next_r.phase = P_IDLE;
			next_r.cmd = 8'h00;
			next_r.cnt = 5'h00;
			next_r.wbits = 5'h00;
			next_r.obits = 4'h0;
			next_r.io_oe_n = 4'hf;
		end
		else if (rise)
		begin
			case (r.phase)
				P_IDLE, P_CMD:
				begin
					next_r.cmd = {r.cmd[6:0], sy.io[0]};
					next_r.cnt = r.cnt + 5'h01;
					next_r.phase = P_CMD;
					if (r.cnt == CMD_LAST)
					begin
						next_r.cnt = 5'h00;
						next_r.phase = P_SKIP;
						case (next_r.cmd)
							OP_STATUS_WRITE_CMD:
								if (!busy)
									next_r.phase = P_WDATA; // R5
							OP_RDSR:
							begin
								next_r.phase = P_DATA;
								next_r.src = SRC_STATUS;
							end
							OP_RDCR:
							begin
								next_r.phase = P_DATA;
								next_r.src = SRC_CONFIG;
							end
							OP_READ:
								next_r.phase = P_ADDR; // R13
							OP_FAST, OP_DOUT, OP_DIO:
								if (!busy)
									next_r.phase = P_ADDR; // R16
							OP_QIO:
								if (!busy && r.qe)
									next_r.phase = P_ADDR; // R16 R21
							default:
								next_r.phase = P_SKIP;
						endcase
					end
				end
				P_ADDR:
				begin
					case (alanes)
						3'h4: an = {r.addr[19:0], sy.io};
						3'h2: an = {r.addr[21:0], sy.io[1:0]}; // R18
						default: an = {r.addr[22:0], sy.io[0]};
					endcase
					next_r.addr = an;
					next_r.cnt = acnt;
					if (acnt == ADDR_BITS)
					begin
						next_r.rd_addr = an;
						next_r.src = SRC_MEM;
						next_r.dcnt = dummy_of(r.cmd, r.dc);
						next_r.phase = (next_r.dcnt == DUMMY_NONE) ?
							P_DATA : P_DUMMY;
					end
				end
				P_DUMMY:
				begin
					// dummy lines are not sampled; host keeps them level
					next_r.dcnt = r.dcnt - 4'h1; // R19
					if (r.dcnt == 4'h1)
						next_r.phase = P_DATA;
				end
				P_WDATA:
				begin
					next_r.wdat = {r.wdat[14:0], sy.io[0]};
					if (r.wbits != WSR_SAT)
						next_r.wbits = r.wbits + 5'h01;
				end
				default:
					next_r.phase = r.phase;
			endcase
		end
		else if (fall && r.phase == P_DATA)
		begin
			// drive on falling edges so the host samples on rising ones
			case (dlanes)
				3'h4:
				begin
					next_r.io_out = b[7:4];
					next_r.io_oe_n = 4'h0;
				end
				3'h2:
				begin
					next_r.io_out[1:0] = b[7:6]; // R17 R18
					next_r.io_oe_n = 4'hc;
				end
				default:
				begin
					next_r.io_out[1] = b[7]; // R13
					next_r.io_oe_n = 4'hd;
				end
			endcase
			next_r.obyte = b << dlanes;
			next_r.obits = r.obits + {1'b0, dlanes};
			if (next_r.obits == BYTE_BITS)
			begin
				next_r.obits = 4'h0;
				if (r.src == SRC_MEM)
					next_r.rd_addr = r.rd_addr + 24'h1; // R14
			end
		end
		next_r.wip_out = next_r.wip_own | ext_busy_i; // R22
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.phase <= P_IDLE;
			r.src <= SRC_MEM;
			r.io_oe_n <= 4'hf;
			r.software_protect_mode <= 1'b1;
		end
		else if (ce_i)
			r <= next_r;
	end

	assign io_out_o = r.io_out;
	assign io_oe_n_o = r.io_oe_n;
	assign rd_addr_o = r.rd_addr;
	assign prog_ok_o = r.prog_ok;
	assign status_o = status_byte;
	assign config_o = {1'b0, r.dc, 2'b00, r.tb, 3'b000};
	assign hardware_protect_mode_o = r.hardware_protect_mode;
	assign software_protect_mode_o = r.software_protect_mode;

	// checks
	property p_dio_dummy;
		@(posedge clock_i) disable iff (rst_i)
		(r.phase == P_ADDR && next_r.phase == P_DUMMY && r.cmd == OP_DIO
			&& ce_i) |=> (r.dcnt == (r.dc ? 4'h8 : 4'h4));
	endproperty
	a_dio_dummy: assert property (p_dio_dummy) else $error("dio dummy"); // R1

	property p_qio_dummy;
		@(posedge clock_i) disable iff (rst_i)
		(r.phase == P_ADDR && next_r.phase == P_DUMMY && r.cmd == OP_QIO
			&& ce_i) |=> (r.dcnt == (r.dc ? 4'ha : 4'h6));
	endproperty
	a_qio_dummy: assert property (p_qio_dummy) else $error("qio dummy"); // R2

	property p_wsr_needs_wel;
		@(posedge clock_i) disable iff (rst_i)
		$rose(r.wip_own) |-> $past(r.write_enable_latch) && !$past(r.hardware_protect_mode);
	endproperty
	a_wsr_needs_wel: assert property (p_wsr_needs_wel) else $error("no wel"); // R3

	property p_wsr_values;
		@(posedge clock_i) disable iff (rst_i)
		$fell(r.wip_own) |-> {r.status_write_disable, r.qe, r.bp} ==
			(r.pend16 ? r.pend[15:10] : r.pend[7:2]);
	endproperty
	a_wsr_values: assert property (p_wsr_values) else $error("sr value"); // R4

	property p_wsr_count;
		@(posedge clock_i) disable iff (rst_i)
		$rose(r.wip_own) |-> ($past(r.wbits) == 5'h08
			|| $past(r.wbits) == 5'h10);
	endproperty
	a_wsr_count: assert property (p_wsr_count) else $error("bad count"); // R6

	property p_wsr_done;
		@(posedge clock_i) disable iff (rst_i)
		$fell(r.wip_own) |-> !r.write_enable_latch ##1 !r.wip_out || ext_busy_i;
	endproperty
	a_wsr_done: assert property (p_wsr_done) else $error("wel kept"); // R7

	property p_hpm_reject;
		@(posedge clock_i) disable iff (rst_i)
		(r.hardware_protect_mode && sy.cs_n && r.phase == P_WDATA) |=> !$rose(r.wip_own);
	endproperty
	a_hpm_reject: assert property (p_hpm_reject) else $error("hpm write"); // R9

	property p_addr_step;
		@(posedge clock_i) disable iff (rst_i)
		($past(r.phase) == P_DATA && $changed(r.rd_addr))
			|-> r.rd_addr == $past(r.rd_addr) + 24'h1;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("addr step"); // R14

	property p_busy_ignore;
		@(posedge clock_i) disable iff (rst_i)
		(busy && r.phase == P_CMD && next_r.phase == P_ADDR)
			|-> next_r.cmd == OP_READ;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("busy read"); // R16

	property p_out_on_fall;
		@(posedge clock_i) disable iff (rst_i)
		(rise && !sy.cs_n) |=> $stable(r.io_out);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("out edge"); // R13

	c_wsr: cover property (@(posedge clock_i) disable iff (rst_i)
		$fell(r.wip_own) && r.pend16);
	c_dio: cover property (@(posedge clock_i) disable iff (rst_i)
		r.phase == P_DATA && r.cmd == OP_DIO && r.obits == 4'h6);
	c_hpm: cover property (@(posedge clock_i) disable iff (rst_i)
		$rose(r.hardware_protect_mode));
endmodule

`default_nettype wire

// ==== flash_pkg.sv ====
// shared constants and types for the serial flash command logic, plus pin sync
`default_nettype none

package flash_pkg;

	// opcodes
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_RDCR = 8'h15;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0b;
	localparam logic [7:0] OP_DOUT = 8'h3b;
	localparam logic [7:0] OP_DIO  = 8'hbb;
	localparam logic [7:0] OP_QIO  = 8'heb;

	// status and configuration bit positions
	localparam int SR_STATUS_WRITE_DISABLE  = 7;
	localparam int SR_QE    = 6;
	localparam int SR_BP_HI = 5;
	localparam int SR_BP_LO = 2;
	localparam int CR_DC    = 6;
	localparam int CR_TB    = 3;

	// dummy clock counts
	localparam logic [3:0] DUMMY_NONE  = 4'h0;
	localparam logic [3:0] DUMMY_FAST  = 4'h8;
	localparam logic [3:0] DUMMY_DOUT  = 4'h8;
	localparam logic [3:0] DUMMY_DIO_0 = 4'h4;
	localparam logic [3:0] DUMMY_DIO_1 = 4'h8;
	localparam logic [3:0] DUMMY_QIO_0 = 4'h6;
	localparam logic [3:0] DUMMY_QIO_1 = 4'ha;

	// bit counts
	localparam logic [4:0] CMD_LAST  = 5'h07;
	localparam logic [4:0] ADDR_BITS = 5'h18;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [4:0] WSR_SHORT = 5'h08;
	localparam logic [4:0] WSR_LONG  = 5'h10;
	localparam logic [4:0] WSR_SAT   = 5'h11;

	// protection geometry: 32 blocks of 64 KiB
	localparam int         BLK_HI    = 20;
	localparam int         BLK_LO    = 16;
	localparam logic [5:0] BLK_COUNT = 6'h20;
	localparam logic [3:0] BP_ALL    = 4'h6;

	// self-timed status write cycle
	localparam int CLOCK_PERIOD_NS      = 20;
	localparam int STATUS_WRITE_TIME_NS = 40000;
	localparam int STATUS_WRITE_CYCLES  =
		(STATUS_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int TIMER_W = 24;

	typedef enum logic [2:0] {
		P_IDLE, P_CMD, P_ADDR, P_DUMMY, P_DATA, P_WDATA, P_SKIP
	} phase_e;

	typedef enum logic [1:0] {SRC_MEM, SRC_STATUS, SRC_CONFIG} src_e;

	// raw or synchronised pin levels
	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] io;
	} pin_in_s;

	localparam pin_in_s PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

	typedef struct packed {
		pin_in_s s1;
		pin_in_s s2;
		logic    sclk_q;
	} sync_s;

	typedef struct packed {
		phase_e               phase;
		src_e                 src;
		logic [7:0]           cmd;
		logic [4:0]           cnt;
		logic [3:0]           dcnt;
		logic [23:0]          addr;
		logic [15:0]          wdat;
		logic [4:0]           wbits;
		logic [7:0]           obyte;
		logic [3:0]           obits;
		logic                 write_enable_latch;
		logic                 wip_own;
		logic                 wip_out;
		logic                 status_write_disable;
		logic                 qe;
		logic [3:0]           bp;
		logic                 dc;
		logic                 tb;
		logic                 hardware_protect_mode;
		logic [15:0]          pend;
		logic                 pend16;
		logic [TIMER_W-1:0]   timer;
		logic [3:0]           io_out;
		logic [3:0]           io_oe_n;
		logic [23:0]          rd_addr;
		logic                 prog_ok;
		logic                 software_protect_mode;
	} state_s;

endpackage

// two-flop synchroniser for the pins, with serial clock edge detection
module pin_sync (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// pins
	input  wire flash_pkg::pin_in_s pins_i,
	output var  flash_pkg::pin_in_s pins_o,
	output logic                   sclk_rise_o,
	output logic                   sclk_fall_o
);
	import flash_pkg::*;

	sync_s r;
	sync_s next_r;

	// edges come from the second stage only, never the first
	always_comb
	begin
		next_r        = r;
		next_r.s1     = pins_i;
		next_r.s2     = r.s1;
		next_r.sclk_q = r.s2.sclk;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			r <= '{s1: PINS_IDLE, s2: PINS_IDLE, sclk_q: 1'b0};
		else if (ce_i)
			r <= next_r;
	end

	assign pins_o      = r.s2;
	assign sclk_rise_o = r.s2.sclk & ~r.sclk_q;
	assign sclk_fall_o = ~r.s2.sclk & r.sclk_q;
endmodule

`default_nettype wire

// ==== spi_host_model.sv ====
// behavioural serial host that frames commands on the flash pins
`default_nettype none
module spi_host_model (
	// protect pin level and resolved io lines
	input  wire logic       wp_i,
	input  wire logic [3:0] io_i,
	// pins driven by the host
	output var  logic       cs_n_o,
	output var  logic       sclk_o,
	output var  logic [3:0] drv_o,
	output var  logic [3:0] en_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle pins: deselected, clock parked low
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		drv_o  = 4'h0;
		en_o   = 4'h0;
	end

	// margins around select edges exceed the device's sync delay
	task automatic cs(input logic lvl);
		#40ns;
		cs_n_o = lvl;
		// deselected: let go of the lines so the protect pin shows wp
		if (lvl)
			en_o = 4'h0;
		#100ns;
	endtask

	// one clock: lines change while low, read back just before the fall
	task automatic tick(input logic [3:0] en, input logic [3:0] v,
		output logic [3:0] got);
		en_o  = en;
		drv_o = v;
		#80ns;
		sclk_o = 1'b1;
		#80ns;
		got    = io_i;
		sclk_o = 1'b0;
	endtask

	// shift n bits out msb first, w lanes per clock
	task automatic send(input logic [31:0] d, input int n, input int w);
		logic [35:0] dd;
		logic [3:0]  v;
		logic [3:0]  g;
		dd = {4'h0, d};
		for (int i = n - w; i >= 0; i -= w)
		begin
			v = dd[i +: 4] & ((4'h1 << w) - 4'h1);
			if (w != 4)
				v[3:2] = {1'b1, wp_i};
			tick((w == 1) ? 4'hd : 4'hf, v, g);
		end
	endtask

	// collect one byte from the device over w lanes
	task automatic recv(output logic [7:0] b, input int w);
		logic [3:0] g;
		b = 8'h00;
		for (int i = 0; i < 8 / w; i++)
		begin
			tick((w == 4) ? 4'h0 : ((w == 2) ? 4'hc : 4'hd),
				{1'b1, wp_i, 2'b00}, g);
			case (w)
				1: b = {b[6:0], g[1]};
				2: b = {b[5:0], g[1:0]};
				default: b = {b[3:0], g};
			endcase
		end
	endtask
endmodule
`default_nettype wire

// ==== tb_flash_status_read.sv ====
// self-checking bench for the flash status write and read sequencer
`default_nettype none
module tb_flash_status_read;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_pkg::*;

	logic        clock_i   = 1'b0;
	logic        rst_i     = 1'b1;
	logic        ext_busy  = 1'b0;
	logic        prog_req  = 1'b0;
	logic [23:0] prog_addr = 24'h0;
	logic        wp        = 1'b1;
	logic        ce        = 1'b1;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  drv;
	logic [3:0]  en;
	logic [3:0]  io_out;
	logic [3:0]  io_oe_n;
	logic [3:0]  io_w;
	pin_in_s     pins;
	logic [23:0] rd_addr;
	logic [7:0]  rd_data;
	logic [7:0]  status;
	logic [7:0]  cfg;
	logic        prog_ok;
	logic        hardware_protect_mode;
	logic        software_protect_mode;
	logic [7:0]  b;
	int          bad_count   = 0;
	int          check_count = 0;
	int          cycles      = 0;

	// memory image: neighbours differ, also across the address wrap, except from an even 64 KiB bank into the next
	function automatic logic [7:0] m(input logic [23:0] a);
		return (a[7:0] + 8'h31) ^ a[23:16];
	endfunction

	// released lines toggle so a stale bit never passes for data;
	// the protect line follows the wp level whenever nobody drives it
	assign io_w = (io_out & ~io_oe_n) | (drv & en & io_oe_n)
		| ({~sclk, wp, ~sclk, ~sclk} & ~en & io_oe_n);
	assign pins    = '{cs_n: cs_n, sclk: sclk, io: io_w};
	assign rd_data = m(rd_addr);

	spi_host_model host_u (
		.wp_i   (wp),
		.io_i   (io_w),
		.cs_n_o (cs_n),
		.sclk_o (sclk),
		.drv_o  (drv),
		.en_o   (en)
	);

	flash_status_read #(
		.WRITE_CYCLES (20)
	) dut_u (
		.clock_i                 (clock_i),
		.rst_i                   (rst_i),
		.ce_i                    (ce),
		.pins_i                  (pins),
		.io_out_o                (io_out),
		.io_oe_n_o               (io_oe_n),
		.ext_busy_i              (ext_busy),
		.rd_data_i               (rd_data),
		.rd_addr_o               (rd_addr),
		.prog_req_i              (prog_req),
		.prog_addr_i             (prog_addr),
		.prog_ok_o               (prog_ok),
		.status_o                (status),
		.config_o                (cfg),
		.hardware_protect_mode_o (hardware_protect_mode),
		.software_protect_mode_o (software_protect_mode)
	);

	// system clock, 50 MHz
	always #10ns clock_i = ~clock_i;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			final_report();
		end
	end

	task automatic write_enable_cmd();
		host_u.cs(1'b0);
		host_u.send({24'h0, OP_WRITE_ENABLE_CMD}, 8, 1);
		host_u.cs(1'b1);
	endtask

	// opcode then n data bits, select raised right after the last bit
	task automatic wsr(input logic [15:0] d, input int n);
		host_u.cs(1'b0);
		host_u.send({24'h0, OP_STATUS_WRITE_CMD}, 8, 1);
		host_u.send({16'h0, d}, n, 1);
		host_u.cs(1'b1);
	endtask

	// wait for the busy flag to drop, bounded
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			@(posedge clock_i);
			#2ns;
			n++;
		end
		while (status[0] !== 1'b0 && n < 200);
		chk(32'(status[0]), 32'h0);
	endtask

	task automatic prog(input logic [23:0] a, input logic exp);
		prog_addr = a;
		prog_req  = 1'b1;
		repeat (2) @(posedge clock_i);
		#2ns;
		chk(32'(prog_ok), 32'(exp));
		prog_req = 1'b0;
	endtask

	// read nb bytes: address on aw lanes, dum dummy clocks, data on dw
	task automatic rd(input logic [7:0] op, input logic [23:0] a,
		input int aw, input int dum, input int dw, input int nb);
		host_u.cs(1'b0);
		host_u.send({24'h0, op}, 8, 1);
		host_u.send({8'h0, a}, 24, aw);
		host_u.send(32'h0, dum * aw, aw);
		for (int i = 0; i < nb; i++)
		begin
			host_u.recv(b, dw);
			chk(32'(b), 32'(m(a + 24'(i))));
		end
		host_u.cs(1'b1);
	endtask

	// read one register byte back over the single serial output
	task automatic rdreg(input logic [7:0] op, input logic [7:0] exp);
		host_u.cs(1'b0);
		host_u.send({24'h0, op}, 8, 1);
		host_u.recv(b, 1);
		chk(32'(b), 32'(exp));
		host_u.cs(1'b1);
	endtask

	// main sequence; every step keeps a 2 ns lag behind the clock edge
	initial
	begin
		repeat (4) @(posedge clock_i);
		#2ns;
		rst_i = 1'b0;
		repeat (5) @(posedge clock_i);
		#2ns;
		chk(32'({status, cfg}), 32'h0);
		chk(32'({io_oe_n, hardware_protect_mode, software_protect_mode}), 32'h3d);
		$display("test reset done");
		wsr(16'h003c, 8);
		chk(32'(status), 32'h0);
		write_enable_cmd();
		chk(32'(status), 32'h02);
		wsr(16'h0abc, 12);
		chk(32'(status), 32'h02);
		wsr(16'h003f, 8);
		chk(32'(status[0]), 32'h1);
		ce = 1'b0;
		repeat (40) @(posedge clock_i);
		#2ns;
		chk(32'(status[0]), 32'h1);
		ce = 1'b1;
		idle();
		chk(32'(status), 32'h3c);
		rdreg(OP_RDSR, 8'h3c);
		$display("test status write done");
		prog(24'h000000, 1'b0);
		write_enable_cmd();
		wsr(16'h0004, 8);
		idle();
		prog(24'h1f0000, 1'b0);
		prog(24'h000000, 1'b1);
		$display("test protect area done");
		write_enable_cmd();
		wsr(16'h0040, 16);
		idle();
		chk(32'({status, cfg}), 32'h0040);
		rdreg(OP_RDCR, 8'h40);
		rd(OP_DIO, 24'h00abcd, 2, 8, 2, 3);
		write_enable_cmd();
		wsr(16'h0000, 16);
		idle();
		rd(OP_DIO, 24'h00abcd, 2, 4, 2, 3);
		rd(OP_READ, 24'hffffff, 1, 0, 1, 2);
		rd(OP_FAST, 24'h000100, 1, 8, 1, 2);
		rd(OP_DOUT, 24'h12345e, 1, 8, 2, 3);
		$display("test reads done");
		ext_busy = 1'b1;
		repeat (2) @(posedge clock_i);
		#2ns;
		chk(32'(status[0]), 32'h1);
		host_u.cs(1'b0);
		host_u.send({24'h0, OP_FAST}, 8, 1);
		host_u.send(32'h100, 32, 1);
		host_u.recv(b, 1);
		chk(32'(io_oe_n), 32'hf);
		host_u.cs(1'b1);
		rd(OP_READ, 24'h000010, 1, 0, 1, 1);
		ext_busy = 1'b0;
		$display("test busy refusal done");
		write_enable_cmd();
		wsr(16'h0080, 8);
		idle();
		chk(32'(status), 32'h80);
		wp = 1'b0;
		repeat (8) @(posedge clock_i);
		#2ns;
		chk(32'({hardware_protect_mode, software_protect_mode}), 32'h2);
		write_enable_cmd();
		wsr(16'h0000, 8);
		idle();
		chk(32'(status[7:2]), 32'h20);
		wp = 1'b1;
		write_enable_cmd();
		chk(32'({hardware_protect_mode, software_protect_mode}), 32'h1);
		wsr(16'h00c0, 8);
		idle();
		chk(32'(status), 32'hc0);
		wp = 1'b0;
		repeat (8) @(posedge clock_i);
		#2ns;
		chk(32'({hardware_protect_mode, software_protect_mode}), 32'h1);
		rd(OP_QIO, 24'h0000fe, 4, 6, 4, 3);
		wp = 1'b1;
		write_enable_cmd();
		wsr(16'h0408, 16);
		idle();
		chk(32'(cfg), 32'h08);
		prog(24'h000000, 1'b0);
		prog(24'h1f0000, 1'b1);
		write_enable_cmd();
		wsr(16'h0000, 16);
		idle();
		chk(32'(cfg), 32'h08);
		$display("test protection modes done");
		final_report();
	end
endmodule
`default_nettype wire
